// ### rtl/bdr_pkg.sv
// shared constants, register map and types of the busbar trip recorder
`default_nettype none
package bdr_pkg;
	localparam int NINST = 3;                     // one instance per phase
	localparam int NFEED = 5;                     // feeders summed per instance
	localparam int MW    = 16;                    // measured value width
	localparam int NBIN  = 3;                     // binary inputs
	typedef logic [MW-1:0] meas_t;
	// timing
	localparam int CLK_HZ         = 100_000_000;
	localparam int REC_RATE_HZ    = 2000;
	localparam int SAMPLE_DIV_DEF = CLK_HZ / REC_RATE_HZ;
	localparam int SUPV_TICKS     = 4;           // persistence in sample ticks
	// recorder geometry
	localparam int N_SLOTS        = 8;
	localparam int REC_TOTAL_MS   = 7000;
	localparam int RETAIN_MS      = 2500;
	localparam int SLOT_SAMPLES   = REC_TOTAL_MS * REC_RATE_HZ / 1000 / N_SLOTS;
	localparam int RETAIN_SAMPLES = RETAIN_MS * REC_RATE_HZ / 1000;
	localparam int RETAIN_SLOTS   = (RETAIN_SAMPLES + SLOT_SAMPLES - 1) / SLOT_SAMPLES;
	localparam int MEM_DEPTH      = N_SLOTS * SLOT_SAMPLES;
	localparam int AW             = 14;
	localparam int SW             = 11;
	// operational values
	localparam int MEAS_MAX_PCT   = 240;
	localparam int RATED_SHIFT    = 10;          // 1024 counts = rated value
	// register offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_PICKUP   = 8'h04;
	localparam logic [7:0] OFF_SLOPE    = 8'h08;
	localparam logic [7:0] OFF_SUPV     = 8'h0C;
	localparam logic [7:0] OFF_CODE     = 8'h10;
	localparam logic [7:0] OFF_CMD      = 8'h14;
	localparam logic [7:0] OFF_STATUS   = 8'h18;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFF_REC_SEL  = 8'h24;
	localparam logic [7:0] OFF_REC_DATA = 8'h28;
	localparam logic [7:0] OFF_MEAS0    = 8'h2C;
	// field positions
	localparam int CTL_LOCKOUT = 0;
	localparam int CTL_TEST    = 1;
	localparam int CTL_F60     = 2;
	localparam int CTL_F16     = 3;
	localparam int CTL_PHASE   = 4;
	localparam int CMD_MRESET  = 0;
	localparam int CMD_SRESET  = 1;
	localparam int EV_TRIP     = 0;
	localparam int EV_ALARM    = 1;
	localparam int EV_REC      = 2;
	// reset values
	localparam logic [4:0]  CTRL_RST   = 5'h01;
	localparam logic [15:0] PICKUP_RST = 16'h0400;
	localparam logic [7:0]  SLOPE_RST  = 8'h80;
	localparam logic [15:0] SUPV_RST   = 16'h0080;
	localparam logic [31:0] CODE_DEF   = 32'h5A5AC3C3;  // arbitrary
	typedef enum logic {REC_IDLE, REC_RUN} rec_e;
endpackage
`default_nettype wire

// ### rtl/rec_mem_if.sv
// port bundle between the recorder and its sample memory
`default_nettype none
interface rec_mem_if;
	import bdr_pkg::*;
	logic          we;
	logic [AW-1:0] waddr;
	logic [31:0]   wdata;
	logic [AW-1:0] raddr;
	logic [31:0]   rdata;
	modport ctrl (output we, waddr, wdata, raddr, input rdata);
	modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ### rtl/rec_mem.sv
// fault record sample memory with registered read data
`default_nettype none
module rec_mem
	import bdr_pkg::*;
(
	input wire logic mclk,     // system clock
	rec_mem_if.mem   m         // recorder side
);
	logic [31:0] ram [MEM_DEPTH];

	////////////////////////////////////////////////////////////////////////
	// one write port, one read port; no reset so it maps onto block ram
	always_ff @(posedge mclk) begin
		if (m.we) begin
			ram[m.waddr] <= m.wdata;
		end
		m.rdata <= ram[m.raddr];
	end
endmodule
`default_nettype wire

// ### rtl/busbar_diff_trip_recorder.sv
// busbar differential trip decision, lockout and fault recorder with apb
`default_nettype none
module busbar_diff_trip_recorder
	import bdr_pkg::*;
#(
	parameter int          SAMPLE_DIV = bdr_pkg::SAMPLE_DIV_DEF, // cycles per sample
	parameter logic [31:0] CODEWORD   = bdr_pkg::CODE_DEF        // access code, arbitrary
)(
	input  wire logic                 mclk,        // 100 MHz clock
	input  wire logic                 reset_n,     // async reset
	input  wire logic                 psel,        // apb select
	input  wire logic                 penable,     // apb enable
	input  wire logic                 pwrite,      // apb direction
	input  wire logic [12:0]          paddr,       // [12:8] unit, [7:0] offset
	input  wire logic [31:0]          pwdata,      // apb write data
	output logic [31:0]               prdata,      // apb read data
	output logic                      pready,      // apb ready
	output logic                      pslverr,     // apb error
	input  wire bdr_pkg::meas_t       id_mag [bdr_pkg::NINST],  // differential
	input  wire bdr_pkg::meas_t       feeder_mag [bdr_pkg::NINST][bdr_pkg::NFEED],
	input  wire logic [bdr_pkg::NBIN-1:0] bin_in,  // 0 reset, 1 block, 2 spare
	input  wire logic                 reset_key,   // front key reset
	input  wire logic [4:0]           node_id,     // bus address strap
	input  wire logic                 nv_trip_in,  // backed-up trip state
	output logic                      nv_trip_out, // trip state to back up
	output logic                      trip_out,    // trip command
	output logic                      alarm_out,   // ct supervision alarm
	output logic [bdr_pkg::NINST-1:0] block_out,   // blocked instances
	output logic [1:0]                freq_code,   // {16.7 Hz, 60 Hz}
	output logic                      irq          // level interrupt
);
	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic meas_t sum_mag(input meas_t f [NFEED]);
		logic [MW+2:0] s;
		s = '0;
		for (int k = 0; k < NFEED; k++) begin
			s = s + (MW+3)'(f[k]);
		end
		return (s > (MW+3)'(16'hFFFF)) ? 16'hFFFF : s[MW-1:0];
	endfunction

	function automatic logic over_char(input meas_t id, input meas_t ir,
			input meas_t pk, input logic [7:0] k);
		logic [23:0] rhs;
		rhs = 24'(ir) * 24'(k);
		return (id > pk) && ({id, 8'h00} > rhs);
	endfunction

	function automatic logic [7:0] pct(input meas_t v);
		logic [22:0] p;
		p = (23'(v) * 23'd100) >> RATED_SHIFT;
		return (p > 23'(MEAS_MAX_PCT)) ? 8'(MEAS_MAX_PCT) : p[7:0];
	endfunction

	function automatic logic [AW-1:0] slot_base(input logic [2:0] s);
		return AW'(s) * AW'(SLOT_SAMPLES);
	endfunction

	function automatic logic [7:0] retain_mask(input logic [2:0] nxt, input logic [3:0] cnt);
		logic [7:0] m;
		logic [2:0] s;
		m = '0;
		s = nxt;
		for (int k = 0; k < RETAIN_SLOTS; k++) begin
			s = s - 3'h1;
			if (4'(k) < cnt) m[s] = 1'b1;
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state
	logic [4:0]       ctrl_q;
	meas_t            pickup_q, supv_thr_q;
	logic [7:0]       slope_q;
	logic             unlocked_q, restored_q;
	logic [4:0]       node_q;
	logic             trip_lat_q, trip_out_q, trip_raw_q;
	logic [NINST-1:0] blk_q;
	logic [2:0]       scnt_q [NINST];
	logic [2:0]       irq_stat_q, irq_mask_q;
	logic [15:0]      div_q;
	rec_e             rec_q;
	logic [2:0]       cur_slot_q, next_slot_q, rd_slot_q;
	logic [SW-1:0]    samp_q, rd_idx_q;
	logic [3:0]       count_q;
	logic [1:0]       rec_inst_q;
	logic [15:0]      meas_q [NINST];
	rec_mem_if        mif ();

	////////////////////////////////////////////////////////////////////////
	// apb decode: zero wait, unit select from upper address bits
	logic [7:0] off;
	logic       hit, wr, rd, mapped;
	assign off    = paddr[7:0];
	assign hit    = restored_q && (paddr[12:8] == node_q);
	assign mapped = (off <= OFF_MEAS0 + 8'h08) && (off[1:0] == 2'b00);
	assign wr     = psel && penable && pwrite && hit && mapped;
	assign rd     = psel && penable && !pwrite && hit && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && hit && !mapped;

	////////////////////////////////////////////////////////////////////////
	// measurement and characteristic per instance
	meas_t            ir [NINST];
	logic [NINST-1:0] over, supv_cond, blk_set, inst_en;
	logic             trip_raw, tick, rec_start, rec_last, man_clr, sreset;
	assign inst_en = ctrl_q[CTL_PHASE] ? 3'b111 : 3'b001;
	always_comb begin
		for (int i = 0; i < NINST; i++) begin
			ir[i]        = sum_mag(feeder_mag[i]);
			over[i]      = inst_en[i] && over_char(id_mag[i], ir[i], pickup_q, slope_q);
			supv_cond[i] = inst_en[i] && (id_mag[i] > supv_thr_q) && !over[i];
			blk_set[i]   = supv_cond[i] && (scnt_q[i] == 3'(SUPV_TICKS));
		end
	end
	// a blocked zone is excluded whatever its characteristic says
	assign trip_raw  = |(over & ~blk_q) && !bin_in[1];
	assign rec_start = trip_raw && !trip_raw_q;
	assign man_clr   = reset_key || bin_in[0] || (wr && off == OFF_CMD && pwdata[CMD_MRESET]);
	assign sreset    = wr && (off == OFF_CMD) && pwdata[CMD_SRESET];

	////////////////////////////////////////////////////////////////////////
	// strap and backed-up trip capture in the first cycle after release
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			restored_q <= 1'b0;
			node_q     <= '0;
		end else if (!restored_q) begin
			restored_q <= 1'b1;
			node_q     <= node_id;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// settings registers; test mode needs a prior codeword
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q     <= CTRL_RST;
			pickup_q   <= PICKUP_RST;
			slope_q    <= SLOPE_RST;
			supv_thr_q <= SUPV_RST;
			unlocked_q <= 1'b0;
			irq_mask_q <= '0;
		end else if (wr) begin
			unique case (off)
				OFF_CTRL: ctrl_q <= {pwdata[4:2], unlocked_q ? pwdata[CTL_TEST] : ctrl_q[CTL_TEST],
					pwdata[CTL_LOCKOUT]};
				OFF_PICKUP:   pickup_q   <= pwdata[15:0];
				OFF_SLOPE:    slope_q    <= pwdata[7:0];
				OFF_SUPV:     supv_thr_q <= pwdata[15:0];
				OFF_CODE:     unlocked_q <= (pwdata == CODEWORD);
				OFF_IRQ_MASK: irq_mask_q <= pwdata[2:0];
				default: ;
			endcase
		end
	end
	assign freq_code = {ctrl_q[CTL_F16], ctrl_q[CTL_F60]};

	////////////////////////////////////////////////////////////////////////
	// trip latch: set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			trip_lat_q <= 1'b0;
			trip_out_q <= 1'b0;
			trip_raw_q <= 1'b0;
		end else begin
			trip_raw_q <= trip_raw;
			trip_out_q <= trip_lat_q && !ctrl_q[CTL_TEST];
			if (!restored_q) begin
				trip_lat_q <= nv_trip_in;
			end else if (trip_raw && !ctrl_q[CTL_TEST]) begin
				trip_lat_q <= 1'b1;
			end else if (!ctrl_q[CTL_LOCKOUT] || man_clr) begin
				trip_lat_q <= 1'b0;
			end
		end
	end
	assign trip_out    = trip_out_q;
	assign nv_trip_out = trip_lat_q;

	////////////////////////////////////////////////////////////////////////
	// ct supervision: condition must persist a few ticks, since a real
	// fault also crosses the sensitive threshold on its way up
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			blk_q <= '0;
			for (int i = 0; i < NINST; i++) scnt_q[i] <= '0;
		end else begin
			for (int i = 0; i < NINST; i++) begin
				if (!supv_cond[i]) scnt_q[i] <= '0;
				else if (tick && scnt_q[i] != 3'(SUPV_TICKS)) scnt_q[i] <= scnt_q[i] + 3'h1;
				if (blk_set[i]) blk_q[i] <= 1'b1;
				else if (sreset) blk_q[i] <= 1'b0;
			end
		end
	end
	assign block_out = blk_q;
	assign alarm_out = |blk_q;

	////////////////////////////////////////////////////////////////////////
	// sample rate divider
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) div_q <= '0;
		else if (tick) div_q <= '0;
		else div_q <= div_q + 16'h1;
	end
	assign tick = (div_q == 16'(SAMPLE_DIV - 1));

	////////////////////////////////////////////////////////////////////////
	// recorder: ring of fixed-length slots; total length fits the budget
	assign rec_last = (rec_q == REC_RUN) && tick && (samp_q == SW'(SLOT_SAMPLES - 1));
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rec_q       <= REC_IDLE;
			cur_slot_q  <= '0;
			next_slot_q <= '0;
			samp_q      <= '0;
			count_q     <= '0;
			rec_inst_q  <= '0;
		end else if (rec_start) begin
			rec_q       <= REC_RUN;
			cur_slot_q  <= next_slot_q;
			next_slot_q <= next_slot_q + 3'h1;
			samp_q      <= '0;
			rec_inst_q  <= over[0] ? 2'd0 : (over[1] ? 2'd1 : 2'd2);
			if (count_q != 4'(N_SLOTS)) count_q <= count_q + 4'h1;
		end else if (rec_q == REC_RUN && tick) begin
			samp_q <= samp_q + SW'(1);
			if (rec_last) rec_q <= REC_IDLE;
		end
	end
	// sample word: upper bits of both currents plus eight state traces
	assign mif.we    = (rec_q == REC_RUN) && tick;
	assign mif.waddr = slot_base(cur_slot_q) + AW'(samp_q);
	assign mif.wdata = {id_mag[rec_inst_q][15:4], ir[rec_inst_q][15:4],
		trip_lat_q, trip_raw, |blk_q, ctrl_q[CTL_TEST], ctrl_q[CTL_LOCKOUT], bin_in};
	assign mif.raddr = slot_base(rd_slot_q) + AW'(rd_idx_q);

	rec_mem rec_mem_inst (
		.mclk (mclk),
		.m    (mif.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// readout pointer; each data read steps to the next sample
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_slot_q <= '0;
			rd_idx_q  <= '0;
		end else if (wr && off == OFF_REC_SEL) begin
			rd_slot_q <= pwdata[18:16];
			rd_idx_q  <= (pwdata[10:0] < SW'(SLOT_SAMPLES)) ? pwdata[10:0] : '0;
		end else if (rd && off == OFF_REC_DATA) begin
			rd_idx_q <= (rd_idx_q == SW'(SLOT_SAMPLES - 1)) ? '0 : rd_idx_q + SW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operational values in percent of rated, refreshed each sample
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NINST; i++) meas_q[i] <= '0;
		end else if (tick) begin
			for (int i = 0; i < NINST; i++) meas_q[i] <= {pct(ir[i]), pct(id_mag[i])};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky events, write one to clear; set wins
	logic [2:0] ev;
	assign ev = {rec_last, |(blk_set & ~blk_q), rec_start};
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) irq_stat_q <= '0;
		else if (wr && off == OFF_IRQ_STAT) irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | ev;
		else irq_stat_q <= irq_stat_q | ev;
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////////////
	// read mux, all sources are registers except the live bin_in field in status
	always_comb begin
		prdata = '0;
		if (rd) begin
			unique case (off)
				OFF_CTRL:     prdata = {27'h0, ctrl_q};
				OFF_PICKUP:   prdata = {16'h0, pickup_q};
				OFF_SLOPE:    prdata = {24'h0, slope_q};
				OFF_SUPV:     prdata = {16'h0, supv_thr_q};
				OFF_STATUS:   prdata = {5'h0, next_slot_q, retain_mask(next_slot_q, count_q),
					count_q, 1'b0, bin_in, rec_q == REC_RUN, ctrl_q[CTL_TEST], unlocked_q,
					blk_q, trip_out_q, trip_lat_q};
				OFF_IRQ_STAT: prdata = {29'h0, irq_stat_q};
				OFF_IRQ_MASK: prdata = {29'h0, irq_mask_q};
				OFF_REC_SEL:  prdata = {13'h0, rd_slot_q, 5'h0, rd_idx_q};
				OFF_REC_DATA: prdata = mif.rdata;
				OFF_MEAS0:    prdata = {16'h0, meas_q[0]};
				OFF_MEAS0 + 8'h04: prdata = {16'h0, meas_q[1]};
				OFF_MEAS0 + 8'h08: prdata = {16'h0, meas_q[2]};
				default:      prdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_start;
		rec_start && (rec_q == REC_IDLE);
	endsequence
	sequence s_quiet;
		!tick [*8];
	endsequence

	a_trip_sets_latch: assert property (restored_q && trip_raw && !ctrl_q[CTL_TEST] |=> trip_lat_q)
		else $error("trip condition did not set latch");
	a_supv_block_alarm: assert property (blk_set[0] |=> blk_q[0] && alarm_out)
		else $error("supervision did not block and alarm");
	a_lockout_hold: assert property (restored_q && trip_lat_q && ctrl_q[CTL_LOCKOUT] && !man_clr |=> trip_lat_q)
		else $error("locked trip dropped without reset");
	a_restore_trip: assert property ($rose(restored_q) |-> trip_lat_q == $past(nv_trip_in))
		else $error("backed-up trip not restored");
	a_test_mute: assert property (ctrl_q[CTL_TEST] && $past(ctrl_q[CTL_TEST]) |-> !trip_out)
		else $error("trip output in test mode");
	a_code_gate: assert property (!unlocked_q && !ctrl_q[CTL_TEST] |=> !ctrl_q[CTL_TEST])
		else $error("test mode set without codeword");
	a_sample_rate: assert property (tick |=> s_quiet)
		else $error("sample ticks too close");
	a_ring_step: assert property (s_start |=> cur_slot_q == $past(next_slot_q)
		&& next_slot_q == $past(next_slot_q) + 3'h1)
		else $error("ring pointer did not advance");
	a_count_cap: assert property (count_q <= 4'(N_SLOTS))
		else $error("record count above slot count");
	a_rec_end: assert property (rec_last && !rec_start |=> rec_q == REC_IDLE)
		else $error("record ran past slot length");
	a_unit_select: assert property (psel && penable && pwrite && !hit |=> $stable(ctrl_q))
		else $error("write from other unit address took effect");
	a_blocked_quiet: assert property (blk_q == inst_en && !rec_start |-> !trip_raw)
		else $error("blocked zone tripped");
endmodule
`default_nettype wire

// ### bench/bus_plant.sv
// plant model: feeder and differential currents seen by the relay
`default_nettype none
module bus_plant
	import bdr_pkg::*;
(
	input  wire logic           mclk,                                      // system clock
	input  wire bdr_pkg::meas_t id_lvl,                                    // commanded differential
	input  wire bdr_pkg::meas_t ir_each,                                   // per-feeder magnitude
	input  wire logic           trip_out,                                  // relay command
	output var  bdr_pkg::meas_t id_mag [bdr_pkg::NINST],                   // differential per phase
	output var  bdr_pkg::meas_t feeder_mag [bdr_pkg::NINST][bdr_pkg::NFEED], // feeder magnitudes
	output int                  trips                                      // breaker commands seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic trip_prev_q;
	// every phase sees the same fault; the relay itself sums the feeders
	always_comb begin
		for (int i = 0; i < NINST; i++) begin
			id_mag[i] = id_lvl;
			for (int j = 0; j < NFEED; j++)
				feeder_mag[i][j] = ir_each;
		end
	end
	// count breaker commands, a held trip counts once
	always_ff @(posedge mclk) begin
		trip_prev_q <= trip_out;
		if (trip_out === 1'b1 && trip_prev_q === 1'b0)
			trips <= trips + 1;
	end
endmodule
`default_nettype wire

// ### bench/tb_busbar_diff_trip_recorder.sv
// self-checking bench of the busbar trip recorder
`default_nettype none
module tb_busbar_diff_trip_recorder
	import bdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] UNIT = 5'h03;
	localparam int         SDIV = 20;   // short sample period keeps the run brief
	logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        er, reset_key, nv_trip_in, nv_trip_out, trip_out, alarm_out, irq;
	logic [2:0]  bin_in, block_out;
	logic [4:0]  node_id;
	logic [1:0]  freq_code;
	meas_t       id_lvl, ir_each;
	meas_t       id_mag [NINST];
	meas_t       feeder_mag [NINST][NFEED];
	int          trips, miscompares, compares, cycles, ntrips;
	busbar_diff_trip_recorder #(.SAMPLE_DIV(SDIV), .CODEWORD(CODE_DEF)) busbar_diff_trip_recorder_inst (
		.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.id_mag(id_mag), .feeder_mag(feeder_mag), .bin_in(bin_in), .reset_key(reset_key),
		.node_id(node_id), .nv_trip_in(nv_trip_in), .nv_trip_out(nv_trip_out), .trip_out(trip_out),
		.alarm_out(alarm_out), .block_out(block_out), .freq_code(freq_code), .irq(irq));
	bus_plant bus_plant_inst (.mclk(mclk), .id_lvl(id_lvl), .ir_each(ir_each), .trip_out(trip_out),
		.id_mag(id_mag), .feeder_mag(feeder_mag), .trips(trips));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic [12:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] o, input logic [31:0] d);
		apb({UNIT, o}, 1'b1, d);
	endtask
	task automatic rdc(input logic [7:0] o, input logic [31:0] exp);
		apb({UNIT, o}, 1'b0, 32'h0);
		chk(rd, exp);
	endtask
	// latch follows one edge after the inputs, trip_out one edge later
	task automatic set_i(input meas_t d, input meas_t f);
		@(posedge mclk);
		id_lvl <= d;
		ir_each <= f;
		repeat (3) @(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rdc(OFF_CTRL, 32'h01);
		rdc(OFF_PICKUP, 32'h0400);
		rdc(OFF_SLOPE, 32'h80);
		rdc(OFF_SUPV, 32'h0080);
		apb({UNIT, 8'h38}, 1'b0, 32'h0);
		chk(er, 1'b1);
		apb({5'h04, OFF_PICKUP}, 1'b1, 32'h10);
		apb({5'h04, OFF_CTRL}, 1'b0, 32'h0);
		chk({rd[30:0], er}, 32'h0);
		rdc(OFF_PICKUP, 32'h0400);
		// 50, 60 and 16.7 Hz selections in turn
		for (int k = 0; k < 3; k++) begin
			wr(OFF_CTRL, {28'h0, k[1:0], 2'b01});
			@(posedge mclk);
			chk(freq_code, k[1:0]);
		end
		wr(OFF_CTRL, 32'h01);
	endtask
	task automatic t_trip();
		wr(OFF_IRQ_MASK, 32'h1);
		set_i(16'h0800, 16'h0334);               // below the slope: restraint 4100
		chk(trip_out, 1'b0);
		// three reset sources: command, front key, binary input
		for (int s = 0; s < 3; s++) begin
			set_i(16'h0800, 16'h0100);
			chk(trip_out, 1'b1);
			chk(irq, 1'b1);
			set_i(16'h0000, 16'h0000);
			chk(trip_out, 1'b1);
			ntrips++;
			if (s == 0)
				wr(OFF_CMD, 32'h1);
			@(posedge mclk);
			reset_key <= (s == 1);
			bin_in <= {2'b00, s == 2};
			@(posedge mclk);
			reset_key <= 1'b0;
			bin_in <= 3'b000;
			repeat (3) @(posedge mclk);
			chk(trip_out, 1'b0);
		end
		wr(OFF_IRQ_STAT, 32'h1);
		@(posedge mclk);                         // the clear lands at the access edge
		chk(irq, 1'b0);
	endtask
	task automatic t_test();
		wr(OFF_CTRL, 32'h03);
		rdc(OFF_CTRL, 32'h01);
		wr(OFF_CODE, CODE_DEF);
		wr(OFF_CTRL, 32'h03);
		rdc(OFF_CTRL, 32'h03);
		bin_in <= 3'b100;
		set_i(16'h0800, 16'h0100);
		ntrips++;
		chk(trip_out, 1'b0);
		apb({UNIT, OFF_STATUS}, 1'b0, 32'h0);
		chk({rd[10:8], rd[0]}, 4'b1000);
		set_i(16'h0000, 16'h0000);
		bin_in <= 3'b000;
		wr(OFF_CTRL, 32'h01);
		wr(OFF_CODE, 32'h0);
	endtask
	task automatic t_supv();
		set_i(16'h0400, 16'h0400);               // at pickup and below slope, above supervision
		repeat (6 * SDIV) @(posedge mclk);
		chk({alarm_out, block_out}, 4'h9);
		// phase-selective mode brings the other two instances under supervision
		wr(OFF_CTRL, 32'h11);
		repeat (6 * SDIV) @(posedge mclk);
		chk({alarm_out, block_out}, 4'hF);
		apb({UNIT, OFF_IRQ_STAT}, 1'b0, 32'h0);
		chk(rd[1], 1'b1);
		rdc(OFF_MEAS0, 32'h0000F064);
		set_i(16'h0800, 16'h0100);
		chk(trip_out, 1'b0);
		set_i(16'h0000, 16'h0000);
		chk(alarm_out, 1'b1);
		wr(OFF_CMD, 32'h2);
		repeat (3) @(posedge mclk);
		chk({alarm_out, block_out}, 4'h0);
	endtask
	task automatic t_rec();
		wr(OFF_CTRL, 32'h00);
		bin_in <= 3'b100;                        // trace-only level to find in the record
		// nine quick faults overrun the eight slots
		repeat (9) begin
			set_i(16'h0800, 16'h0100);
			set_i(16'h0000, 16'h0000);
			ntrips++;
		end
		apb({UNIT, OFF_STATUS}, 1'b0, 32'h0);
		chk(rd[26:24], ntrips % 8);
		chk(rd[15:12], 4'h8);
		chk(rd[23:16], 8'h1C);                   // newest three slots behind the pointer
		chk(rd[7], 1'b1);
		chk(trips, ntrips - 1);                  // only the muted fault missed the breaker
		// let the first sample of the newest record land before reading it
		repeat (2 * SDIV) @(posedge mclk);
		wr(OFF_REC_SEL, ((ntrips - 1) % 8) << 16);
		apb({UNIT, OFF_REC_DATA}, 1'b0, 32'h0);
		chk(rd[5:0], 6'h04);
		bin_in <= 3'b000;
		// the newest record runs its full slot length, then reports completion
		repeat ((SLOT_SAMPLES - 10) * SDIV) @(posedge mclk);
		apb({UNIT, OFF_STATUS}, 1'b0, 32'h0);
		chk(rd[7], 1'b1);
		apb({UNIT, OFF_IRQ_STAT}, 1'b0, 32'h0);
		chk(rd[2], 1'b0);
		repeat (20 * SDIV) @(posedge mclk);
		apb({UNIT, OFF_STATUS}, 1'b0, 32'h0);
		chk(rd[7], 1'b0);
		apb({UNIT, OFF_IRQ_STAT}, 1'b0, 32'h0);
		chk(rd[2], 1'b1);
	endtask
	task automatic t_nv();
		@(posedge mclk);
		nv_trip_in <= 1'b1;
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({trip_out, nv_trip_out}, 2'b11);
		wr(OFF_CMD, 32'h1);
		repeat (3) @(posedge mclk);
		chk({trip_out, nv_trip_out}, 2'b00);
	endtask
	////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// hang guard: generous against the ~36000 cycles the scenarios need,
	// most of them spent waiting for one full record slot
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			close_out();
		end
	end
	// main sequence
	initial begin
		{psel, penable, pwrite, reset_key, nv_trip_in, reset_n} = 6'h0;
		{paddr, pwdata, bin_in} = '0;
		{id_lvl, ir_each} = '0;
		node_id = UNIT;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs();
		t_trip();
		t_test();
		t_supv();
		t_rec();
		t_nv();
		close_out();
	end
endmodule
`default_nettype wire
